// ### hdl/nfh_pkg.sv
package nfh_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_EXEC    = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_EXEC    = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_EXEC   = 8'hd0;
  // software register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_COL    = 4'h1;
  localparam logic [3:0] REG_ROW    = 4'h2;
  localparam logic [3:0] REG_DATA   = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PINS   = 4'h5;
  // control and status field positions
  localparam int CTRL_GO_LSB = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_WP_BIT = 3;
  localparam int CTRL_CE_BIT = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_RB_BIT    = 1;
  localparam int STAT_DVAL_BIT  = 2;
  localparam int STAT_DREQ_BIT  = 3;
  // address geometry
  localparam int COL_BITS   = 12;
  localparam int ROW_BITS   = 19;
  localparam int PAGE_BYTES = 2048 + 64;
  localparam int BLOCK_PAGES = 64;
  // timing: a write-strobe phase is this many clocks, each phase at least 25 ns
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          PHASE_NS      = 25;
  localparam int          PHASE_CYC     = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WB_NS         = 100;
  localparam int          WB_CYC        = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  RESET_CTRL    = 8'h18;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10,
    OP_NONE  = 2'b11
  } nfh_op_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD1    = 4'h1,
    ST_ADDR    = 4'h2,
    ST_DIN     = 4'h3,
    ST_CMD2    = 4'h4,
    ST_WAITB   = 4'h5,
    ST_WAITR   = 4'h6,
    ST_DOUT    = 4'h7,
    ST_DOUT_W  = 4'h8
  } nfh_state_t;

  // flash pin bundle driven by the host
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] dq_out;
    logic       dq_oe_n;
  } nfh_pins_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } nfh_bus_t;
endpackage : nfh_pkg

// ### hdl/nfh_host.sv
`timescale 1ns/1ps
// How it works
// RULE1 - one byte-wide two-way port carries commands, addresses, and data both ways
// RULE2 - host releases the data port whenever the flash may drive it
// RULE3 - command bytes are sent with command strobe high, latched on write-strobe rise
// RULE4 - address bytes are sent with address strobe high, latched on write-strobe rise
// RULE5 - data bytes are sent with both latch strobes low on write-strobe rise
// RULE6 - each read-strobe fall yields the next byte; column advances by one
// RULE7 - flash ignores chip deselect while busy; host keeps select low anyway
// RULE8 - write protect low blocks program and erase in the flash
// RULE9 - ready/busy low during program, erase, page read; host waits for high
// RULE10 - ready/busy is open drain and valid even when deselected
// RULE11 - address bytes one and two carry column bits zero to eleven
// RULE12 - bytes three to five carry page, plane and block index
// RULE13 - unused high bits of address bytes two and five are driven low
// RULE14 - flash discards extra address bytes; host sends only the needed count
// RULE15 - address bit thirty selects die; kept low for a single-die part
// RULE16 - page register holds 2048 plus 64 bytes moved as one page
// RULE17 - erase acts on a whole block of 64 pages
// RULE18 - program and erase run autonomously inside the flash until ready
// RULE19 - page read fills page register while busy, within 25 us
// RULE20 - writes happen only with chip select low and write strobe pulsed low
// RULE21 - read, program and erase use setup and execute command bytes
// RULE22 - erase sends only the three row address bytes
// RULE23 - each programmed data byte goes to the current column, then column advances
module nfh_host #(
  parameter bit DUAL_DIE_PACKAGE = 1'b0
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire nfh_pkg::nfh_bus_t bus_i,
  output logic [7:0]            rdata_o,
  output nfh_pkg::nfh_pins_t    pins_o,
  input  wire logic [7:0]       dq_i,
  input  wire logic             ready_busy_n_i
);
  import nfh_pkg::*;

  // the phase counter is three bits wide
  if (PHASE_CYC < 1 || PHASE_CYC > 7 || WB_CYC < 1 || WB_CYC > 7) begin : g_bad_timing
    $error("timing counts do not fit the phase counter");
  end

  typedef struct packed {
    nfh_state_t            st;
    nfh_op_t               op;
    logic                  go;
    logic [7:0]            ctrl;
    logic [COL_BITS-1:0]   col;
    logic [ROW_BITS-1:0]   row;
    logic [7:0]            wbyte;
    logic                  wfull;
    logic [7:0]            rbyte;
    logic                  rvalid;
    logic [2:0]            acnt;
    logic [1:0]            sub;
    logic [2:0]            tcnt;
    logic [COL_BITS:0]     left;
    logic [7:0]            rdata;
    logic                  rb_m;
    logic                  rb_s;
    logic [7:0]            dq_m;
    logic [7:0]            dq_s;
    nfh_pins_t             pins;
  } nfh_state_all_t;

  nfh_state_all_t s_q, s_d;
  logic [7:0] abyte;
  logic [7:0] cbyte;

  assign rdata_o = s_q.rdata;
  assign pins_o  = s_q.pins;

  // address byte mux, unused bits low
  always_comb begin
    unique case (s_q.acnt)
      3'd0:    abyte = s_q.col[7:0];                                   // RULE11
      3'd1:    abyte = {4'h0, s_q.col[11:8]};                          // RULE13
      3'd2:    abyte = s_q.row[7:0];                                   // RULE12
      3'd3:    abyte = s_q.row[15:8];
      default: abyte = {5'h00, (DUAL_DIE_PACKAGE & s_q.row[18]), s_q.row[17:16]}; // RULE15
    endcase
    unique case ({s_q.st == ST_CMD2, s_q.op})
      {1'b0, OP_READ}:  cbyte = CMD_READ_SETUP;                        // RULE21
      {1'b0, OP_PROG}:  cbyte = CMD_PROG_SETUP;
      {1'b0, OP_ERASE}: cbyte = CMD_ERASE_SETUP;
      {1'b1, OP_READ}:  cbyte = CMD_READ_EXEC;
      {1'b1, OP_PROG}:  cbyte = CMD_PROG_EXEC;
      {1'b1, OP_ERASE}: cbyte = CMD_ERASE_EXEC;
      default:          cbyte = 8'hff;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.dq_m = dq_i;
    s_d.dq_s = s_q.dq_m;
    s_d.rb_m = ready_busy_n_i;
    s_d.rb_s = s_q.rb_m;                                               // RULE10
    s_d.pins.wp_n = s_q.ctrl[CTRL_WP_BIT];                             // RULE8
    s_d.go = 1'b0;
    // software port
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        REG_CTRL: begin
          s_d.ctrl = bus_i.wdata;
          if (bus_i.wdata[CTRL_GO_LSB] && s_q.st == ST_IDLE && s_q.tcnt == 3'd0) begin
            s_d.go = 1'b1;
            s_d.op = nfh_op_t'(bus_i.wdata[CTRL_OP_LSB +: 2]);
          end
        end
        // both shift in from below: high part first, low byte last
        REG_COL:  s_d.col = {s_q.col[3:0], bus_i.wdata};
        REG_ROW:  s_d.row = {s_q.row[ROW_BITS-9:0], bus_i.wdata};
        REG_DATA: begin
          s_d.wbyte = bus_i.wdata;
          s_d.wfull = 1'b1;
        end
        default: ;
      endcase
    end
    s_d.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        REG_CTRL:   s_d.rdata = s_q.ctrl;
        REG_COL:    s_d.rdata = s_q.col[7:0];
        REG_ROW:    s_d.rdata = s_q.row[7:0];
        REG_DATA: begin
          s_d.rdata  = s_q.rbyte;
          s_d.rvalid = 1'b0;
        end
        REG_STATUS: s_d.rdata = {4'h0, s_q.st == ST_DIN && !s_q.wfull,
                                 s_q.rvalid, s_q.rb_s,
                                 s_q.st != ST_IDLE || s_q.tcnt != 3'd0};
        REG_PINS:   s_d.rdata = s_q.dq_s;
        default:    s_d.rdata = 8'h00;
      endcase
    end
    // sequencer
    if (s_q.tcnt != 3'd0) begin
      s_d.tcnt = s_q.tcnt - 3'd1;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.pins.ce_n    = !s_q.ctrl[CTRL_CE_BIT] && !s_q.go;
          s_d.pins.dq_oe_n = 1'b1;                                     // RULE2
          if (s_q.go && s_q.op != OP_NONE) begin
            s_d.pins.ce_n = 1'b0;                                      // RULE20
            s_d.st  = ST_CMD1;
            s_d.sub = 2'd0;
          end
        end
        ST_CMD1, ST_CMD2, ST_ADDR, ST_DIN: begin
          // write cycle: strobe low, then high
          s_d.pins.dq_oe_n = 1'b0;                                     // RULE1
          s_d.tcnt = 3'(PHASE_CYC - 1);
          if (s_q.sub == 2'd0) begin
            // latch strobes move only here and in ST_WAITB, well after the last write-strobe rise
            s_d.pins.cle = s_q.st == ST_CMD1 || s_q.st == ST_CMD2;     // RULE3
            s_d.pins.ale = s_q.st == ST_ADDR;                          // RULE4
            if (s_q.st == ST_DIN && !s_q.wfull) begin
              s_d.tcnt = 3'd0;
              if (!s_q.ctrl[CTRL_GO_LSB])
                s_d.st = ST_CMD2;
            end else begin
              s_d.pins.dq_out = s_q.st == ST_ADDR ? abyte :
                                s_q.st == ST_DIN  ? s_q.wbyte : cbyte; // RULE5
              s_d.pins.we_n = 1'b0;                                    // RULE20
              s_d.sub = 2'd1;
            end
          end else begin
            s_d.pins.we_n = 1'b1;
            s_d.sub = 2'd0;
            unique case (s_q.st)
              ST_CMD1: begin
                s_d.st   = ST_ADDR;
                s_d.acnt = s_q.op == OP_ERASE ? 3'd2 : 3'd0;            // RULE22
              end
              ST_ADDR: begin
                s_d.acnt = s_q.acnt + 3'd1;
                if (s_q.acnt == 3'd4) begin                            // RULE14
                  s_d.st   = s_q.op == OP_PROG ? ST_DIN : ST_CMD2;
                  s_d.left = 13'(PAGE_BYTES) - {1'b0, s_q.col};
                end
              end
              ST_DIN: begin
                // a byte written in this cycle wins over the clear
                s_d.wfull = bus_i.wr && bus_i.addr == REG_DATA;
                s_d.col   = s_q.col + 12'd1;                           // RULE23
                s_d.left  = s_q.left - 13'd1;
                if (s_q.left == 13'd1 || !s_q.ctrl[CTRL_GO_LSB])
                  s_d.st = ST_CMD2;                                    // RULE16
              end
              default: begin
                s_d.st   = ST_WAITB;
                s_d.tcnt = 3'(WB_CYC);
              end
            endcase
          end
        end
        ST_WAITB: begin
          s_d.pins.dq_oe_n = 1'b1;
          s_d.pins.cle     = 1'b0;
          s_d.pins.ale     = 1'b0;
          s_d.st = ST_WAITR;
        end
        ST_WAITR: begin
          // ce stays low while busy
          if (s_q.rb_s) begin                                          // RULE9 RULE18 RULE19
            s_d.st  = s_q.op == OP_READ ? ST_DOUT : ST_IDLE;           // RULE17 RULE7
            s_d.sub = 2'd0;
            if (s_q.op == OP_READ)
              s_d.left = 13'(PAGE_BYTES) - {1'b0, s_q.col};
          end
        end
        ST_DOUT: begin
          if (s_q.sub == 2'd0) begin
            if (!s_q.ctrl[CTRL_GO_LSB]) begin
              s_d.st = ST_IDLE;
            end else if (!s_q.rvalid) begin
              s_d.pins.read_strobe_n = 1'b0;                           // RULE6
              s_d.tcnt = 3'(PHASE_CYC);
              s_d.sub  = 2'd1;
            end
          end else begin
            s_d.st = ST_DOUT_W;
          end
        end
        ST_DOUT_W: begin
          s_d.rbyte  = s_q.dq_s;
          s_d.rvalid = 1'b1;
          s_d.pins.read_strobe_n = 1'b1;
          s_d.col  = s_q.col + 12'd1;                                  // RULE6
          s_d.left = s_q.left - 13'd1;
          s_d.sub  = 2'd0;
          s_d.tcnt = 3'(PHASE_CYC - 1);
          s_d.st   = (s_q.left == 13'd1 || !s_q.ctrl[CTRL_GO_LSB]) ? ST_IDLE : ST_DOUT;
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    if (rst_i) begin
      s_d = '0;
      s_d.st   = ST_IDLE;
      s_d.op   = OP_NONE;
      s_d.ctrl = RESET_CTRL;
      s_d.rb_m = 1'b1;
      s_d.rb_s = 1'b1;
      s_d.pins.ce_n          = 1'b1;
      s_d.pins.we_n          = 1'b1;
      s_d.pins.read_strobe_n = 1'b1;
      s_d.pins.wp_n          = 1'b0;
      s_d.pins.dq_oe_n       = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_q <= s_d;
  end
endmodule : nfh_host

// ### tb/nfh_host_properties.sv
`timescale 1ns/1ps
module nfh_host_properties (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire nfh_pkg::nfh_bus_t  bus_i,
  input  wire logic [7:0]         rdata_o,
  input  wire nfh_pkg::nfh_pins_t pins_o,
  input  wire logic [7:0]         dq_i,
  input  wire logic               ready_busy_n_i
);
  import nfh_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  chk_latch_excl: assert property (!(pins_o.cle && pins_o.ale))
    else $error("both latch strobes high");
  chk_write_select: assert property (!pins_o.we_n |-> !pins_o.ce_n)
    else $error("write strobe without chip select");
  chk_write_drive: assert property (!pins_o.we_n |-> !pins_o.dq_oe_n)
    else $error("write strobe with port released");
  chk_read_release: assert property (!pins_o.read_strobe_n |-> pins_o.dq_oe_n && pins_o.we_n)
    else $error("port driven while reading");
  chk_write_pulse: assert property ($fell(pins_o.we_n) |-> ##1 !pins_o.we_n ##1 pins_o.we_n[*2])
    else $error("write pulse shape wrong");
  chk_latch_hold: assert property ($rose(pins_o.we_n) |->
    $stable(pins_o.cle) && $stable(pins_o.ale) && $stable(pins_o.dq_out))
    else $error("byte or strobe moved at latch edge");
  chk_read_pulse: assert property ($fell(pins_o.read_strobe_n) |->
    ##1 !pins_o.read_strobe_n[*3] ##1 pins_o.read_strobe_n)
    else $error("read pulse shape wrong");
  chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  cov_read: cover property ($fell(pins_o.read_strobe_n));
  cov_erase: cover property (pins_o.cle && $rose(pins_o.we_n) && pins_o.dq_out == CMD_ERASE_EXEC);
  cov_addr: cover property ($rose(pins_o.ale));
endmodule : nfh_host_properties
bind nfh_host nfh_host_properties nfh_host_properties_i (.mclk_i(mclk_i), .rst_i(rst_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .pins_o(pins_o), .dq_i(dq_i),
  .ready_busy_n_i(ready_busy_n_i));

// ### tb/nfh_flash_model.sv
`timescale 1ns/1ps
module nfh_flash_model #(
  parameter int T_READ_NS  = 2000,
  parameter int T_PROG_NS  = 4000,
  parameter int T_ERASE_NS = 8000
) (
  input  wire nfh_pkg::nfh_pins_t pins_i,
  input  wire logic [7:0]         io_i,
  output logic [7:0]              io_o,
  output logic                    io_drv_o,
  output logic                    ready_busy_n_o,
  output logic                    fault_o
);
  import nfh_pkg::*;
  logic [7:0]  arr [logic [30:0]];
  logic [7:0]  pg [PAGE_BYTES];
  logic [7:0]  ab [5];
  logic [7:0]  cmd = 8'h00;
  logic [11:0] col = 12'h000;
  logic [18:0] row = 19'h00000;
  int          acnt = 0;
  int          need;
  wire         sel = (pins_i.ce_n === 1'b0);
  initial begin
    io_o = 8'h00;
    io_drv_o = 1'b0;
    ready_busy_n_o = 1'b1;
    fault_o = 1'b0;
  end
  always @(posedge pins_i.we_n) begin
    need = (cmd == CMD_ERASE_SETUP) ? 3 : 5;
    if (sel && pins_i.cle === 1'b1) begin
      cmd = io_i;
      acnt = 0;
      if (cmd == CMD_PROG_SETUP) foreach (pg[i]) pg[i] = 8'hff;
      ready_busy_n_o = !(cmd == CMD_READ_EXEC ||
        pins_i.wp_n && (cmd == CMD_PROG_EXEC || cmd == CMD_ERASE_EXEC));
      if (!ready_busy_n_o) begin
        #(cmd == CMD_READ_EXEC ? T_READ_NS : cmd == CMD_PROG_EXEC ? T_PROG_NS : T_ERASE_NS);
        foreach (pg[i]) begin
          if (cmd == CMD_READ_EXEC) pg[i] = arr.exists({row, 12'(i)}) ? arr[{row, 12'(i)}] : 8'hff;
          if (cmd == CMD_PROG_EXEC) arr[{row, 12'(i)}] = pg[i];
        end
        if (cmd == CMD_ERASE_EXEC) foreach (arr[k]) if (k[30:18] == row[18:6]) arr[k] = 8'hff;
        ready_busy_n_o = 1'b1;
      end
    end else if (sel && pins_i.ale === 1'b1 && acnt < need) begin
      ab[acnt] = io_i;
      acnt++;
      if (acnt == 2 && need == 5 && io_i[7:4] != 4'h0) fault_o = 1'b1;
      if (acnt == need && io_i[7:2] != 6'h00) fault_o = 1'b1;
      if (acnt == need) begin
        col = (need == 5) ? {ab[1][3:0], ab[0]} : 12'h000;
        row = (need == 5) ? {ab[4][2:0], ab[3], ab[2]} : {ab[2][2:0], ab[1], ab[0]};
      end
    end else if (sel && pins_i.ale === 1'b0 && col < PAGE_BYTES) begin
      pg[col] = io_i;
      col++;
    end
  end
  always @(negedge pins_i.read_strobe_n) begin
    if (sel && col < PAGE_BYTES) begin
      io_o = pg[col];
      io_drv_o = 1'b1;
      col++;
    end
  end
  always @(posedge pins_i.read_strobe_n or posedge pins_i.ce_n) io_drv_o = 1'b0;
endmodule : nfh_flash_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import nfh_pkg::*;
  localparam logic [18:0] ROW = 19'h03a4b;
  localparam logic [11:0] COL = 12'h7fe;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  nfh_bus_t   bus = '0;
  nfh_pins_t  pins;
  logic [7:0] rdata, fdq, rd;
  logic       fdrv, rb_n, fault;
  int         miscompares = 0;
  int         tests_run = 0;
  // released port shows the flash byte while the flash drives, else the inverse of its last byte
  wire [7:0]  dq = (pins.dq_oe_n === 1'b0) ? pins.dq_out : fdrv ? fdq : ~fdq;
  always #10 mclk_i = ~mclk_i;
  nfh_host nfh_host_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .pins_o(pins), .dq_i(dq), .ready_busy_n_i(rb_n));
  nfh_flash_model nfh_flash_model_i (.pins_i(pins), .io_i(dq), .io_o(fdq), .io_drv_o(fdrv),
    .ready_busy_n_o(rb_n), .fault_o(fault));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk_i);
    bus <= '0;
    #1 rd = rdata;
    @(posedge mclk_i);
  endtask : acc
  task automatic poll(input int b, input logic v);
    int n;
    for (n = 0; n < 4000; n++) begin
      acc(1'b0, REG_STATUS, 8'h00);
      if (rd[b] === v) break;
    end
    if (n == 4000) begin
      miscompares++;
      end_of_test();
    end
  endtask : poll
  function automatic logic [7:0] pat(input int i);
    return 8'h3c ^ 8'(i * 29);
  endfunction : pat
  task automatic op(input logic [18:0] r, input logic [7:0] ctl, input int n);
    acc(1'b1, REG_COL, {4'h0, COL[11:8]});
    acc(1'b1, REG_COL, COL[7:0]);
    acc(1'b1, REG_ROW, {5'h00, r[18:16]});
    acc(1'b1, REG_ROW, r[15:8]);
    acc(1'b1, REG_ROW, r[7:0]);
    acc(1'b1, REG_CTRL, ctl);
    for (int i = 0; i < n; i++) begin
      poll(ctl[1] ? STAT_DREQ_BIT : STAT_DVAL_BIT, 1'b1);
      acc(ctl[1], REG_DATA, pat(i));
      if (!ctl[1]) chk("read byte", i < 4 ? pat(i) : 8'hff, rd);
    end
    if (n > 0) acc(1'b1, REG_CTRL, ctl & 8'hfe);
    poll(STAT_BUSY_BIT, 1'b0);
  endtask : op
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 chk("wp_n in reset", 8'h00, 8'(pins.wp_n));
    chk("ce_n in reset", 8'h01, 8'(pins.ce_n));
    @(posedge mclk_i);
    op(ROW, 8'h1b, 4);
    for (int i = 0; i < 4; i++) begin
      chk("stored byte", pat(i), nfh_flash_model_i.arr[{ROW, COL + 12'(i)}]);
    end
    op(ROW, 8'h19, 5);
    op(ROW ^ 19'h0003f, 8'h13, 2);
    chk("protected page", 8'h00, 8'(nfh_flash_model_i.arr.exists({ROW ^ 19'h0003f, COL})));
    op(ROW ^ 19'h0003f, 8'h1d, 0);
    chk("erased byte", 8'hff, nfh_flash_model_i.arr[{ROW, COL}]);
    acc(1'b0, 4'hf, 8'h00);
    chk("unmapped read", 8'h00, rd);
    acc(1'b0, REG_ROW, 8'h00);
    chk("row low byte", 8'(ROW ^ 19'h0003f), rd);
    chk("address fault", 8'h00, 8'(fault));
    end_of_test();
  end
endmodule : testbench
